//--- hw/pebb_bridge.sv
// Purpose: Bus interface unit joining the host processor bus and the expansion bus.
// Assumes: exp_clk is the bus clock; bus pins are synchronous to it.
// Notes: Host side on ref_clk; toggles and held words cross between domains.
`timescale 1ns/1ps
`default_nettype none
// Function
// - Watchdog forces an acknowledge 256 bus cycles after a stalled start.
// - Outbound engine engages for host memory addresses 6000_0000 to FFFF_FFFF.
// - Outbound request is synchronised and sent with the identical address.
// - A timed-out outbound access returns a processor bus fault.
// - Host access to F0xx_xxxx faults at once, no bus transaction.
// - Inbound 0000_0000 to 3FFF_FFFF requests host bus, RAM access same address.
// - Inbound F080_0000 to F0FF_FFFF maps to host ROM at 4x80_0000 upward.
// - Top address nibble 4 decodes as ROM; middle bits ignored.
// - Resource-lock attention is recorded and holds the next transaction locked.
// - Bus tracker runs on the bus clock following every bus state.
// - Bus clock is 100 ns, 75 ns high then 25 ns low.
// - Drive and release on rising edge, sample on falling edge.
// - Every bus signal is asserted low.
// - Only reads and writes in one address space travel the bus.
// - Card interrupts arrive on the non-master request line.
// - Slots are peers; only the main board drives the clock.
// - Main board presents a fixed identification code to each slot.
// - Transactions may last any number of clock periods.
// - Address and data share the 32-bit bus; host side keeps them apart.
// - Word, halfword and byte transfers pass without lane justification; inbound byte transfers reach the host as halfwords.
// - Only single-word transactions are carried out.
// - Transaction is start cycle, optional waits, one acknowledge cycle.
// - Start with acknowledge asserted is an attention cycle.
module pebb_bridge #(
    parameter logic [3:0] ROM_ALIAS = 4'h0
) (
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire logic exp_clk,
    input wire logic host_start,
    input wire pebb_pkg::pebb_xfer_t host_xfer,
    input wire logic host_mem_space,
    output logic host_ack,
    output logic [31:0] host_rdata,
    output logic processor_bus_fault,
    output logic host_rom_sel,
    output logic card_irq,
    output logic mem_req,
    input wire logic mem_grant,
    input wire logic mem_ack,
    input wire logic [31:0] mem_rdata,
    output pebb_pkg::pebb_xfer_t mem_xfer,
    output logic mem_rom_sel,
    output logic mem_lock,
    input wire logic exp_nmrq_n,
    input wire pebb_pkg::pebb_bus_t exp_in_n,
    output pebb_pkg::pebb_bus_t exp_out_n,
    output pebb_pkg::pebb_bus_t exp_oe,
    output logic [pebb_pkg::NUM_SLOTS*4-1:0] exp_id_n
);
    function automatic logic is_rom(input logic [31:0] a);
        return a[31:28] == pebb_pkg::ROM_NIBBLE;
    endfunction

    // Host domain state.
    pebb_pkg::pebb_out_st_t o_state_reg, o_state_next;
    pebb_pkg::pebb_in_st_t i_state_reg, i_state_next;
    logic [pebb_pkg::SYNC_H-1:0] h_s1_reg, h_s2_reg, h_s3_reg;
    logic [1:0] h_seen_reg, h_seen_next, h_ev;
    logic irq_reg, irq_next, lockl_reg, lockl_next;
    logic out_tgl_reg, out_tgl_next, inb_tgl_reg, inb_tgl_next;
    pebb_pkg::pebb_xfer_t out_xfer_reg, out_xfer_next, mem_xfer_reg, mem_xfer_next;
    logic ack_reg, ack_next, fault_reg, fault_next, rsel_reg, rsel_next;
    logic [31:0] rdata_reg, rdata_next, inb_rdata_reg, inb_rdata_next;
    logic mreq_reg, mreq_next, mrom_reg, mrom_next;

    // Link domain state.
    pebb_pkg::pebb_mst_st_t m_state_reg, m_state_next;
    pebb_pkg::pebb_slv_st_t s_state_reg, s_state_next;
    pebb_pkg::pebb_bus_t smp_reg, drv_reg, drv_next, oe_reg, oe_next;
    logic [pebb_pkg::SYNC_L-1:0] l_s1_reg, l_s2_reg, l_s3_reg;
    logic [1:0] l_seen_reg, l_seen_next, l_ev;
    pebb_pkg::pebb_xfer_t m_xfer_reg, m_xfer_next, s_xfer_reg, s_xfer_next;
    logic [31:0] m_rdata_reg, m_rdata_next;
    logic m_err_reg, m_err_next, m_tgl_reg, m_tgl_next, s_tgl_reg, s_tgl_next;
    logic busy_reg, busy_next, lock_reg, lock_next, ltxn_reg, ltxn_next;
    logic [pebb_pkg::WD_W-1:0] wd_cnt_reg, wd_cnt_next;
    logic wd_fire, s_hit;

    assign h_ev[0] = (h_s2_reg[0] == h_s3_reg[0]) && (h_s3_reg[0] != h_seen_reg[0]);
    assign h_ev[1] = (h_s2_reg[1] == h_s3_reg[1]) && (h_s3_reg[1] != h_seen_reg[1]);

    always_comb begin
        o_state_next = o_state_reg;
        out_xfer_next = out_xfer_reg;
        out_tgl_next = out_tgl_reg;
        ack_next = 1'b0;
        fault_next = 1'b0;
        rdata_next = rdata_reg;
        h_seen_next = h_seen_reg;
        rsel_next = host_start && is_rom(host_xfer.addr);
        irq_next = (h_s2_reg[2] == h_s3_reg[2]) ? !h_s3_reg[2] : irq_reg;
        lockl_next = (h_s2_reg[3] == h_s3_reg[3]) ? h_s3_reg[3] : lockl_reg;
        unique case (o_state_reg)
            pebb_pkg::H_IDLE: begin
                if (host_start && host_mem_space && host_xfer.addr >= pebb_pkg::OUT_BASE) begin
                    if (host_xfer.addr[31:24] == pebb_pkg::OWN_SLOT_BYTE) begin
                        fault_next = 1'b1;
                    end else begin
                        out_xfer_next = host_xfer;
                        out_tgl_next = !out_tgl_reg;
                        o_state_next = pebb_pkg::H_WAIT;
                    end
                end
            end
            pebb_pkg::H_WAIT: begin
                if (h_ev[0]) begin
                    h_seen_next[0] = h_s3_reg[0];
                    fault_next = m_err_reg;
                    ack_next = !m_err_reg;
                    rdata_next = m_rdata_reg;
                    o_state_next = pebb_pkg::H_IDLE;
                end
            end
        endcase
    end

    always_comb begin
        i_state_next = i_state_reg;
        mem_xfer_next = mem_xfer_reg;
        mrom_next = mrom_reg;
        mreq_next = mreq_reg;
        inb_tgl_next = inb_tgl_reg;
        inb_rdata_next = inb_rdata_reg;
        unique case (i_state_reg)
            pebb_pkg::I_IDLE: begin
                if (h_ev[1]) begin
                    mem_xfer_next = s_xfer_reg;
                    if (s_xfer_reg.addr[31:23] == pebb_pkg::ROM_IN_TOP9) begin
                        mem_xfer_next.addr = {pebb_pkg::ROM_NIBBLE, ROM_ALIAS,
                            s_xfer_reg.addr[pebb_pkg::ROM_KEEP_W-1:0]};
                    end
                    mrom_next = is_rom(mem_xfer_next.addr);
                    mreq_next = 1'b1;
                    i_state_next = pebb_pkg::I_ACC;
                end
            end
            pebb_pkg::I_ACC: begin
                if (mem_grant && mem_ack) begin
                    inb_rdata_next = mem_rdata;
                    mreq_next = 1'b0;
                    inb_tgl_next = !inb_tgl_reg;
                    i_state_next = pebb_pkg::I_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            o_state_reg <= pebb_pkg::H_IDLE;
            i_state_reg <= pebb_pkg::I_IDLE;
            h_s1_reg <= '0;
            h_s2_reg <= '0;
            h_s3_reg <= '0;
            h_seen_reg <= '0;
            irq_reg <= 1'b0;
            lockl_reg <= 1'b0;
            out_tgl_reg <= 1'b0;
            inb_tgl_reg <= 1'b0;
            out_xfer_reg <= '0;
            mem_xfer_reg <= '0;
            ack_reg <= 1'b0;
            fault_reg <= 1'b0;
            rsel_reg <= 1'b0;
            rdata_reg <= '0;
            inb_rdata_reg <= '0;
            mreq_reg <= 1'b0;
            mrom_reg <= 1'b0;
        end else begin
            o_state_reg <= o_state_next;
            i_state_reg <= i_state_next;
            h_s1_reg <= {lock_reg, exp_nmrq_n, s_tgl_reg, m_tgl_reg};
            h_s2_reg <= h_s1_reg;
            h_s3_reg <= h_s2_reg;
            h_seen_reg <= {i_state_reg == pebb_pkg::I_IDLE && h_ev[1] ? h_s3_reg[1]
                : h_seen_reg[1], h_seen_next[0]};
            irq_reg <= irq_next;
            lockl_reg <= lockl_next;
            out_tgl_reg <= out_tgl_next;
            inb_tgl_reg <= inb_tgl_next;
            out_xfer_reg <= out_xfer_next;
            mem_xfer_reg <= mem_xfer_next;
            ack_reg <= ack_next;
            fault_reg <= fault_next;
            rsel_reg <= rsel_next;
            rdata_reg <= rdata_next;
            inb_rdata_reg <= inb_rdata_next;
            mreq_reg <= mreq_next;
            mrom_reg <= mrom_next;
        end
    end

    assign host_ack = ack_reg;
    assign host_rdata = rdata_reg;
    assign processor_bus_fault = fault_reg;
    assign host_rom_sel = rsel_reg;
    assign card_irq = irq_reg;
    assign mem_req = mreq_reg;
    assign mem_xfer = mem_xfer_reg;
    assign mem_rom_sel = mrom_reg;
    assign mem_lock = lockl_reg;

    // Bus lines are sampled on the falling edge and inverted to active high.
    always_ff @(negedge exp_clk or negedge arst_n) begin
        if (!arst_n) begin
            smp_reg <= '0;
        end else begin
            smp_reg <= ~exp_in_n;
        end
    end

    assign l_ev[0] = (l_s2_reg[0] == l_s3_reg[0]) && (l_s3_reg[0] != l_seen_reg[0]);
    assign l_ev[1] = (l_s2_reg[1] == l_s3_reg[1]) && (l_s3_reg[1] != l_seen_reg[1]);
    assign s_hit = smp_reg.ad[31:30] == pebb_pkg::RAM_TOP2
        || smp_reg.ad[31:23] == pebb_pkg::ROM_IN_TOP9;
    assign wd_fire = busy_reg && !smp_reg.ack
        && wd_cnt_reg == pebb_pkg::WD_W'(pebb_pkg::WD_CYCLES - 1);

    always_comb begin
        m_state_next = m_state_reg;
        s_state_next = s_state_reg;
        m_xfer_next = m_xfer_reg;
        s_xfer_next = s_xfer_reg;
        m_rdata_next = m_rdata_reg;
        m_err_next = m_err_reg;
        m_tgl_next = m_tgl_reg;
        s_tgl_next = s_tgl_reg;
        l_seen_next = l_seen_reg;
        drv_next = '0;
        oe_next = '0;
        // Bus tracker: busy from a plain start until any acknowledge.
        busy_next = busy_reg;
        if (smp_reg.ack) begin
            busy_next = 1'b0;
        end else if (smp_reg.start) begin
            busy_next = 1'b1;
        end
        wd_cnt_next = wd_cnt_reg;
        if (smp_reg.start) begin
            wd_cnt_next = '0;
        end else if (busy_reg && !smp_reg.ack) begin
            wd_cnt_next = wd_cnt_reg + 1'b1;
        end
        lock_next = lock_reg;
        ltxn_next = ltxn_reg;
        if (smp_reg.start && smp_reg.ack) begin
            lock_next = lock_reg || smp_reg.tm == pebb_pkg::TM_ATTN_LOCK;
        end else if (lock_reg && smp_reg.start) begin
            ltxn_next = 1'b1;
        end else if (ltxn_reg && smp_reg.ack) begin
            lock_next = 1'b0;
            ltxn_next = 1'b0;
        end
        if (wd_fire) begin
            drv_next.ack = 1'b1;
            oe_next.ack = 1'b1;
            drv_next.tm = pebb_pkg::TM_ACK_TIMEOUT;
            oe_next.tm = 2'h3;
        end
        unique case (m_state_reg)
            pebb_pkg::M_IDLE: begin
                if (l_ev[0] && !busy_reg && !smp_reg.start) begin
                    l_seen_next[0] = l_s3_reg[0];
                    m_xfer_next = out_xfer_reg;
                    drv_next.start = 1'b1;
                    drv_next.ad = out_xfer_reg.addr;
                    drv_next.tm[pebb_pkg::TM_WR_BIT] = out_xfer_reg.we;
                    drv_next.tm[pebb_pkg::TM_PART_BIT] = out_xfer_reg.size
                        != pebb_pkg::SIZE_WORD;
                    oe_next.start = 1'b1;
                    oe_next.ad = '1;
                    oe_next.tm = 2'h3;
                    m_state_next = pebb_pkg::M_START;
                end
            end
            pebb_pkg::M_START: begin
                m_state_next = pebb_pkg::M_WAIT;
            end
            pebb_pkg::M_WAIT: begin
                if (smp_reg.ack && !smp_reg.start) begin
                    m_rdata_next = smp_reg.ad;
                    m_err_next = smp_reg.tm == pebb_pkg::TM_ACK_TIMEOUT;
                    m_tgl_next = !m_tgl_reg;
                    m_state_next = pebb_pkg::M_IDLE;
                end
            end
        endcase
        if (m_state_next == pebb_pkg::M_WAIT && m_xfer_next.we) begin
            drv_next.ad = m_xfer_next.data;
            oe_next.ad = '1;
        end
        unique case (s_state_reg)
            pebb_pkg::S_IDLE: begin
                if (smp_reg.start && !smp_reg.ack && s_hit) begin
                    s_xfer_next.addr = smp_reg.ad;
                    s_xfer_next.we = smp_reg.tm[pebb_pkg::TM_WR_BIT];
                    s_xfer_next.size = smp_reg.tm[pebb_pkg::TM_PART_BIT]
                        ? pebb_pkg::SIZE_HALF : pebb_pkg::SIZE_WORD;
                    s_state_next = pebb_pkg::S_DATA;
                end
            end
            pebb_pkg::S_DATA: begin
                s_xfer_next.data = smp_reg.ad;
                s_tgl_next = !s_tgl_reg;
                s_state_next = pebb_pkg::S_HOST;
            end
            pebb_pkg::S_HOST: begin
                if (l_ev[1]) begin
                    l_seen_next[1] = l_s3_reg[1];
                    s_state_next = pebb_pkg::S_IDLE;
                    if (busy_next && !wd_fire) begin
                        drv_next.ack = 1'b1;
                        oe_next.ack = 1'b1;
                        drv_next.tm = pebb_pkg::TM_ACK_DONE;
                        oe_next.tm = 2'h3;
                        drv_next.ad = inb_rdata_reg;
                        oe_next.ad = s_xfer_reg.we ? '0 : '1;
                        s_state_next = pebb_pkg::S_ACK;
                    end
                end
            end
            pebb_pkg::S_ACK: begin
                s_state_next = pebb_pkg::S_IDLE;
            end
        endcase
    end

    // All drive changes happen on the rising edge of the bus clock.
    always_ff @(posedge exp_clk or negedge arst_n) begin
        if (!arst_n) begin
            m_state_reg <= pebb_pkg::M_IDLE;
            s_state_reg <= pebb_pkg::S_IDLE;
            l_s1_reg <= '0;
            l_s2_reg <= '0;
            l_s3_reg <= '0;
            l_seen_reg <= '0;
            m_xfer_reg <= '0;
            s_xfer_reg <= '0;
            m_rdata_reg <= '0;
            m_err_reg <= 1'b0;
            m_tgl_reg <= 1'b0;
            s_tgl_reg <= 1'b0;
            busy_reg <= 1'b0;
            lock_reg <= 1'b0;
            ltxn_reg <= 1'b0;
            wd_cnt_reg <= '0;
            drv_reg <= '0;
            oe_reg <= '0;
        end else begin
            m_state_reg <= m_state_next;
            s_state_reg <= s_state_next;
            l_s1_reg <= {inb_tgl_reg, out_tgl_reg};
            l_s2_reg <= l_s1_reg;
            l_s3_reg <= l_s2_reg;
            l_seen_reg <= l_seen_next;
            m_xfer_reg <= m_xfer_next;
            s_xfer_reg <= s_xfer_next;
            m_rdata_reg <= m_rdata_next;
            m_err_reg <= m_err_next;
            m_tgl_reg <= m_tgl_next;
            s_tgl_reg <= s_tgl_next;
            busy_reg <= busy_next;
            lock_reg <= lock_next;
            ltxn_reg <= ltxn_next;
            wd_cnt_reg <= wd_cnt_next;
            drv_reg <= drv_next;
            oe_reg <= oe_next;
        end
    end

    // The bus clock is an input only; the board never drives it here.
    assign exp_out_n = ~drv_reg;
    assign exp_oe = oe_reg;

    genvar g;
    generate
        for (g = 0; g < pebb_pkg::NUM_SLOTS; g++) begin : g_slot_id
            localparam logic [3:0] ID_N = ~(pebb_pkg::SLOT_ID_FIRST + 4'(g));
            logic [3:0] id_reg;
            always_ff @(posedge ref_clk or negedge arst_n) begin
                if (!arst_n) begin
                    id_reg <= ID_N;
                end else begin
                    id_reg <= ID_N;
                end
            end
            assign exp_id_n[g*4 +: 4] = id_reg;
        end
    endgenerate

    sequence s_master_start;
        m_state_reg == pebb_pkg::M_IDLE && m_state_next == pebb_pkg::M_START;
    endsequence
    sequence s_one_start;
        oe_reg.start && drv_reg.start ##1 !oe_reg.start;
    endsequence

    a_start_one_cycle: assert property (@(posedge exp_clk) disable iff (!arst_n)
        s_master_start |=> s_one_start)
        else $error("start not driven for exactly one cycle");
    a_start_same_addr: assert property (@(posedge exp_clk) disable iff (!arst_n)
        s_master_start |=> drv_reg.ad == m_xfer_reg.addr && m_xfer_reg == out_xfer_reg)
        else $error("outbound address differs from host address");
    a_watchdog_ack: assert property (@(posedge exp_clk) disable iff (!arst_n)
        busy_reg && !smp_reg.ack && wd_cnt_reg == 9'h0FF |=> oe_reg.ack && drv_reg.ack
        && drv_reg.tm == pebb_pkg::TM_ACK_TIMEOUT)
        else $error("watchdog did not force acknowledge");
    a_watchdog_clear: assert property (@(posedge exp_clk) disable iff (!arst_n)
        smp_reg.start |=> wd_cnt_reg == '0)
        else $error("watchdog count not cleared by start");
    a_timeout_error: assert property (@(posedge exp_clk) disable iff (!arst_n)
        m_state_reg == pebb_pkg::M_WAIT && smp_reg.ack && !smp_reg.start
        && smp_reg.tm == pebb_pkg::TM_ACK_TIMEOUT |=> m_err_reg && $changed(m_tgl_reg))
        else $error("timeout not flagged as error");
    a_lock_record: assert property (@(posedge exp_clk) disable iff (!arst_n)
        smp_reg.start && smp_reg.ack && smp_reg.tm == pebb_pkg::TM_ATTN_LOCK |=> lock_reg)
        else $error("resource lock not recorded");
    a_own_slot_fault: assert property (@(posedge ref_clk) disable iff (!arst_n)
        o_state_reg == pebb_pkg::H_IDLE && host_start && host_mem_space
        && host_xfer.addr[31:24] == pebb_pkg::OWN_SLOT_BYTE
        |=> processor_bus_fault && $stable(out_tgl_reg) ##1 !processor_bus_fault)
        else $error("own slot access did not fault at once");
    a_outbound_engage: assert property (@(posedge ref_clk) disable iff (!arst_n)
        o_state_reg == pebb_pkg::H_IDLE && host_start && host_mem_space
        && host_xfer.addr >= pebb_pkg::OUT_BASE
        && host_xfer.addr[31:24] != pebb_pkg::OWN_SLOT_BYTE
        |=> o_state_reg == pebb_pkg::H_WAIT && $changed(out_tgl_reg))
        else $error("outbound engine did not engage");
    a_rom_translate: assert property (@(posedge ref_clk) disable iff (!arst_n)
        i_state_reg == pebb_pkg::I_IDLE && h_ev[1]
        && s_xfer_reg.addr[31:23] == pebb_pkg::ROM_IN_TOP9
        |=> mem_req && mem_rom_sel && mem_xfer.addr[31:28] == pebb_pkg::ROM_NIBBLE
        && mem_xfer.addr[23:0] == s_xfer_reg.addr[23:0])
        else $error("inbound ROM window not translated");
    a_ram_same_addr: assert property (@(posedge ref_clk) disable iff (!arst_n)
        i_state_reg == pebb_pkg::I_IDLE && h_ev[1]
        && s_xfer_reg.addr[31:30] == pebb_pkg::RAM_TOP2
        |=> mem_req && mem_xfer.addr == s_xfer_reg.addr && !mem_rom_sel)
        else $error("inbound RAM access address changed");
endmodule // pebb_bridge
`default_nettype wire

//--- hw/pebb_pkg.sv
// Purpose: Shared constants and types for the processor to expansion bus bridge.
// Assumes: Expansion bus values in these types are active high; pins invert.
// Notes: Transfer mode and status codes are local encodings.
package pebb_pkg;
    localparam int EXP_PERIOD_NS = 100;
    localparam int EXP_HIGH_NS = 75;
    localparam int EXP_LOW_NS = 25;
    localparam int WD_TIME_NS = 25600;
    localparam int WD_CYCLES = WD_TIME_NS / EXP_PERIOD_NS;
    localparam int WD_W = 9;
    localparam logic [31:0] OUT_BASE = 32'h6000_0000;
    localparam logic [7:0] OWN_SLOT_BYTE = 8'hF0;
    localparam logic [1:0] RAM_TOP2 = 2'h0;
    localparam logic [8:0] ROM_IN_TOP9 = 9'h1E1;
    localparam logic [3:0] ROM_NIBBLE = 4'h4;
    localparam int ROM_KEEP_W = 24;
    localparam int TM_WR_BIT = 1;
    localparam int TM_PART_BIT = 0;
    localparam logic [1:0] TM_ACK_DONE = 2'h0;
    localparam logic [1:0] TM_ACK_TIMEOUT = 2'h3;
    localparam logic [1:0] TM_ATTN_LOCK = 2'h2;
    localparam logic [1:0] SIZE_BYTE = 2'h0;
    localparam logic [1:0] SIZE_HALF = 2'h1;
    localparam logic [1:0] SIZE_WORD = 2'h2;
    localparam logic [3:0] SLOT_ID_FIRST = 4'h9;
    localparam int NUM_SLOTS = 6;
    localparam int SYNC_H = 4;
    localparam int SYNC_L = 2;

    typedef struct packed {
        logic [31:0] addr;
        logic [31:0] data;
        logic we;
        logic [1:0] size;
    } pebb_xfer_t;

    typedef struct packed {
        logic start;
        logic ack;
        logic [1:0] tm;
        logic [31:0] ad;
    } pebb_bus_t;

    typedef enum {H_IDLE, H_WAIT} pebb_out_st_t;
    typedef enum {I_IDLE, I_ACC} pebb_in_st_t;
    typedef enum {M_IDLE, M_START, M_WAIT} pebb_mst_st_t;
    typedef enum {S_IDLE, S_DATA, S_HOST, S_ACK} pebb_slv_st_t;
endpackage

//--- testbench/pebb_card_model.sv
// Purpose: Behavioural slot card that answers reads and writes on the expansion bus.
// Assumes: Lines are terminated high, so a released line reads as deasserted.
// Notes: Answers only the slot 9 super space, after a programmable wait count.
`timescale 1ns/1ps
`default_nettype none
module pebb_card_model (
    input wire logic exp_clk,
    input wire pebb_pkg::pebb_bus_t bus_n,
    input wire logic [3:0] waits,
    input wire logic [31:0] rdata,
    output var pebb_pkg::pebb_bus_t drv_n,
    output var pebb_pkg::pebb_bus_t drv_oe
);
    logic pend = 1'b0;
    logic rd = 1'b0;
    logic [3:0] cnt = 4'h0;
    initial begin
        drv_n = '1;
        drv_oe = '0;
    end
    // Plain start cycles are taken on the falling edge; attention cycles are not.
    always @(negedge exp_clk) begin
        if (!bus_n.start && bus_n.ack && ~bus_n.ad[31:28] == 4'h9) begin
            pend <= 1'b1;
            rd <= bus_n.tm[1];
        end
    end
    // Waits, then one acknowledge cycle with data for reads, on rising edges.
    always @(posedge exp_clk) begin
        drv_oe <= '0;
        drv_n <= '1;
        cnt <= pend ? cnt + 4'h1 : 4'h0;
        if (pend && cnt == waits) begin
            pend <= 1'b0;
            drv_n <= {1'b1, 1'b0, 2'b11, ~rdata};
            drv_oe <= {1'b0, 1'b1, 2'b11, {32{rd}}};
        end
    end
endmodule // pebb_card_model
`default_nettype wire

//--- testbench/pebb_bridge_tb.sv
// Purpose: Self-checking bench for the host and expansion bus sides of the bridge.
// Assumes: One card model answers the slot 9 super space.
// Notes: Expected host answers are queued and matched by a monitor.
`timescale 1ns/1ps
`default_nettype none
module pebb_bridge_tb;
    logic ref_clk = 1'b0;
    logic exp_clk = 1'b1;
    logic arst_n, host_start, host_mem_space, exp_nmrq_n, host_ack, processor_bus_fault;
    logic host_rom_sel, card_irq;
    logic [31:0] host_rdata, rdata;
    logic [3:0] waits;
    logic [23:0] exp_id_n;
    logic [33:0] n;
    logic [33:0] notes[$];
    logic [33:0] m;
    logic [33:0] mem_notes[$];
    logic mem_req, mem_rom_sel, mem_lock;
    logic [31:0] a_in;
    pebb_pkg::pebb_xfer_t host_xfer, mem_xfer;
    pebb_pkg::pebb_bus_t bus_n, exp_out_n, exp_oe, card_n, card_oe, mst_n;
    int n_errors = 0;
    int checked = 0;
    int seed = 7602;
    always #5 ref_clk = ~ref_clk;
    always begin
        #22.5 exp_clk = 1'b0;
        #7.5 exp_clk = 1'b1;
    end
    // Open-collector style wire: any driver pulls low, else the terminator holds high.
    assign bus_n = (exp_out_n | ~exp_oe) & (card_n | ~card_oe) & mst_n;
    pebb_bridge pebb_bridge_i (.ref_clk(ref_clk), .arst_n(arst_n), .exp_clk(exp_clk),
        .host_start(host_start), .host_xfer(host_xfer), .host_mem_space(host_mem_space),
        .host_ack(host_ack), .host_rdata(host_rdata), .processor_bus_fault(processor_bus_fault),
        .host_rom_sel(host_rom_sel), .card_irq(card_irq), .mem_req(mem_req), .mem_grant(1'b1),
        .mem_ack(1'b1), .mem_rdata(rdata), .mem_xfer(mem_xfer), .mem_rom_sel(mem_rom_sel),
        .mem_lock(mem_lock),
        .exp_nmrq_n(exp_nmrq_n), .exp_in_n(bus_n), .exp_out_n(exp_out_n), .exp_oe(exp_oe),
        .exp_id_n(exp_id_n));
    pebb_card_model pebb_card_model_i (.exp_clk(exp_clk), .bus_n(bus_n), .waits(waits),
        .rdata(rdata), .drv_n(card_n), .drv_oe(card_oe));
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("Error %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic finish_test();
        if (n_errors == 0 && checked > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask
    task automatic host_req(input logic [31:0] a, input logic we, input logic ms,
                            input logic [33:0] note, input bit push, input int lim);
        @(posedge ref_clk);
        if (push) notes.push_back(note);
        host_start <= 1'b1;
        host_xfer <= '{addr: a, data: $random(seed), we: we, size: 2'({$random(seed)} % 3)};
        host_mem_space <= ms;
        @(posedge ref_clk);
        host_start <= 1'b0;
        @(negedge ref_clk);
        check("rom select", {31'h0, a[31:28] == pebb_pkg::ROM_NIBBLE}, {31'h0, host_rom_sel});
        for (int i = 0; i < lim && notes.size() != 0; i++) @(posedge ref_clk);
        if (notes.size() != 0) check("answer in time", 32'h0, 32'h1);
        notes.delete();
        repeat (push ? 4 : 300) @(posedge ref_clk);
    endtask
    // A card masters one read: start cycle, release, then wait for the acknowledge.
    task automatic inbound(input logic [31:0] a, input logic [31:0] ta, input bit lk);
        mem_notes.push_back({lk, ta[31:28] == pebb_pkg::ROM_NIBBLE, ta});
        @(posedge exp_clk) mst_n <= '{start: 1'b0, ack: 1'b1, tm: 2'b11, ad: ~a};
        @(posedge exp_clk) mst_n <= '1;
        for (int i = 0; i < 100 && bus_n.ack !== 1'b0; i++) @(negedge exp_clk);
        check("bus ack", 32'h0, {31'h0, bus_n.ack});
        check("bus read data", rdata, ~bus_n.ad);
    endtask
    always @(negedge ref_clk) begin
        if (mem_req === 1'b1) begin
            if (mem_notes.size() == 0) check("unrequested host access", 32'h0, 32'h1);
            else begin
                m = mem_notes.pop_front();
                check("host address", m[31:0], mem_xfer.addr);
                check("host rom select", {31'h0, m[32]}, {31'h0, mem_rom_sel});
                check("bus lock", {31'h0, m[33]}, {31'h0, mem_lock});
            end
        end
    end
    always @(negedge ref_clk) begin
        if (host_ack === 1'b1 || processor_bus_fault === 1'b1) begin
            if (notes.size() == 0) check("unrequested answer", 32'h0, 32'h1);
            else begin
                n = notes.pop_front();
                check("bus fault", {31'h0, n[33]}, {31'h0, processor_bus_fault});
                if (n[32]) check("read data", n[31:0], host_rdata);
            end
        end
    end
    initial begin
        #200000;
        n_errors++;
        finish_test();
    end
    initial begin
        arst_n = 1'b0; host_start = 1'b0; host_xfer = '0; host_mem_space = 1'b0;
        exp_nmrq_n = 1'b1; waits = 4'h0; rdata = 32'h0; mst_n = '1;
        repeat (2) @(posedge exp_clk);
        @(posedge ref_clk) arst_n <= 1'b1;
        repeat (3) @(posedge ref_clk);
        for (int g = 0; g < pebb_pkg::NUM_SLOTS; g++)
            check("slot id", {28'h0, ~(4'h9 + 4'(g))}, {28'h0, exp_id_n[4*g +: 4]});
        host_req({8'hF0, 24'($random(seed))}, 1'b0, 1'b1, {2'b10, 32'h0}, 1'b1, 3);
        host_req(32'h5FFF_FFFF, 1'b0, 1'b1, 34'h0, 1'b0, 0);
        host_req({4'h4, 28'($random(seed))}, 1'b0, 1'b1, 34'h0, 1'b0, 0);
        host_req(32'h9000_0000, 1'b0, 1'b0, 34'h0, 1'b0, 0);
        host_req(32'hA000_0000, 1'b0, 1'b1, {2'b10, 32'h0}, 1'b1, 2000);
        for (int k = 0; k < 6; k++) begin
            waits <= (k == 0) ? 4'h0 : 4'($random(seed));
            rdata <= $random(seed);
            @(posedge ref_clk);
            host_req({4'h9, 28'($random(seed))}, k[0], 1'b1, {1'b0, ~k[0], rdata}, 1'b1, 400);
        end
        exp_nmrq_n <= 1'b0;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk) check("card irq", 32'h1, {31'h0, card_irq});
        @(posedge ref_clk) exp_nmrq_n <= 1'b1;
        repeat (6) @(posedge ref_clk);
        @(negedge ref_clk) check("card irq", 32'h0, {31'h0, card_irq});
        a_in = {2'b00, 30'($random(seed))};
        inbound(a_in, a_in, 1'b0);
        a_in = {9'h1E1, 23'($random(seed))};
        inbound(a_in, {8'h40, a_in[23:0]}, 1'b0);
        @(posedge exp_clk) mst_n <= '{start: 1'b0, ack: 1'b0, tm: 2'b01, ad: '1};
        inbound(a_in, {8'h40, a_in[23:0]}, 1'b1);
        repeat (8) @(posedge ref_clk);
        if (mem_notes.size() != 0) check("host access in time", 32'h0, 32'h1);
        finish_test();
    end
endmodule // pebb_bridge_tb
`default_nettype wire
